/* logic/salm_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module salm_monitor
    import salm_pkg::*;
(
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              scan_start,
    input  wire logic              reading_valid,
    input  wire salm_reading_type  reading,
    output logic                   irq
);

    // ==========================================================
    // Helpers
    // ==========================================================
    function automatic logic [QPTR_W-1:0] qinc(input logic [QPTR_W-1:0] p);
        qinc = (p == QLAST_V) ? '0 : p + 1'b1;
    endfunction

    function automatic logic [31:0] status_word(input logic [CH_W-1:0] ch, input logic [1:0] num,
                                                input logic al, input logic hi, input logic lo);
        logic [31:0] w;
        w = '0;
        w[ST_ALARM_BIT] = al;
        w[ST_HIGH_BIT] = hi;
        w[ST_LOW_BIT] = lo;
        w[ST_NUM_LSB +: 2] = num;
        w[ST_CH_LSB +: CH_W] = ch;
        return w;
    endfunction

    // ==========================================================
    // State
    // ==========================================================
    logic signed [DATA_W-1:0] high_reg  [NUM_CH];
    logic signed [DATA_W-1:0] low_reg   [NUM_CH];
    salm_mode_type            mode_reg  [NUM_CH];
    logic [1:0]               anum_reg  [NUM_CH];
    logic [31:0]              meas_reg  [NUM_CH];
    logic [CH_W-1:0]          ch_sel_reg;
    salm_mem_entry_type       mem_reg   [MEM_DEPTH];
    logic [MEM_CNT_W-1:0]     mem_count_reg;
    logic [MEM_IDX_W-1:0]     mem_index_reg;
    salm_queue_entry_type     q_reg     [QDEPTH];
    logic [QPTR_W-1:0]        q_head_reg;
    logic [QPTR_W-1:0]        q_tail_reg;
    logic [QPTR_W-1:0]        q_count_reg;
    logic [EV_W-1:0]          int_status_reg;
    logic [EV_W-1:0]          int_enable_reg;
    logic [31:0]              prdata_reg;
    logic                     pready_reg;
    logic                     pslverr_reg;
    logic                     irq_reg;

    assign prdata  = prdata_reg;
    assign pready  = pready_reg;
    assign pslverr = pslverr_reg;
    assign irq     = irq_reg;

    // ==========================================================
    // Bus decode
    // ==========================================================
    // Requests are acted on in the setup cycle, so every access answers after one wait-free access phase.
    logic setup;
    logic wr;
    logic rd;
    logic factory;
    logic preset;
    logic signed [DATA_W-1:0] wdata_s;
    logic signed [DATA_W-1:0] sel_high;
    logic signed [DATA_W-1:0] sel_low;
    logic high_ok;
    logic low_ok;
    logic mapped;

    assign setup    = psel && !penable;
    assign wr       = setup && pwrite;
    assign rd       = setup && !pwrite;
    assign factory  = wr && paddr == OFF_CTRL && pwdata[CTRL_FACTORY_BIT];
    assign preset   = wr && paddr == OFF_CTRL && pwdata[CTRL_PRESET_BIT];
    assign wdata_s  = signed'(pwdata);
    assign sel_high = high_reg[ch_sel_reg];
    assign sel_low  = low_reg[ch_sel_reg];
    assign high_ok  = wdata_s >= sel_low;
    assign low_ok   = wdata_s <= sel_high;

    always_comb begin
        case (paddr)
            OFF_CTRL, OFF_CH_SEL, OFF_CH_CFG, OFF_CH_HIGH, OFF_CH_LOW, OFF_MEAS_CFG,
            OFF_INT_STATUS, OFF_INT_CLEAR, OFF_INT_ENABLE, OFF_Q_COUNT, OFF_Q_INFO,
            OFF_Q_TIME, OFF_Q_READING, OFF_MEM_COUNT, OFF_MEM_INDEX, OFF_MEM_DATA,
            OFF_MEM_STATUS: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    // ==========================================================
    // Limit checking of incoming readings
    // ==========================================================
    logic signed [DATA_W-1:0] r_high;
    logic signed [DATA_W-1:0] r_low;
    salm_mode_type            r_mode;
    logic                     r_hi_hit;
    logic                     r_lo_hit;
    logic                     r_alarm;
    logic [1:0]               r_num;

    assign r_high   = high_reg[reading.channel];
    assign r_low    = low_reg[reading.channel];
    assign r_mode   = mode_reg[reading.channel];
    assign r_num    = anum_reg[reading.channel];
    assign r_hi_hit = (r_mode == high_limit_only_mode || r_mode == both_limits_mode)
                      && reading.value > r_high;
    assign r_lo_hit = (r_mode == low_limit_only_mode || r_mode == both_limits_mode)
                      && reading.value < r_low;
    assign r_alarm  = reading_valid && (r_hi_hit || r_lo_hit);

    // ==========================================================
    // Channel configuration and limits
    // ==========================================================
    // Limits have a power-on default but are otherwise cleared only by factory reset or reconfiguration.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < NUM_CH; i++) begin
                high_reg[i] <= '0;
                low_reg[i]  <= '0;
                mode_reg[i] <= alarm_off_mode;
                anum_reg[i] <= '0;
                meas_reg[i] <= '0;
            end
        end else if (factory) begin
            for (int i = 0; i < NUM_CH; i++) begin
                high_reg[i] <= '0;
                low_reg[i]  <= '0;
                mode_reg[i] <= alarm_off_mode;
            end
        end else if (wr) begin
            // Preset writes fall through here and touch no channel state.
            case (paddr)
                OFF_MEAS_CFG: begin
                    meas_reg[ch_sel_reg] <= pwdata;
                    mode_reg[ch_sel_reg] <= alarm_off_mode;
                    high_reg[ch_sel_reg] <= '0;
                    low_reg[ch_sel_reg]  <= '0;
                end
                OFF_CH_CFG: begin
                    anum_reg[ch_sel_reg] <= pwdata[CFG_ALARM_LSB +: 2];
                    mode_reg[ch_sel_reg] <= salm_mode_type'(pwdata[CFG_MODE_LSB +: 2]);
                end
                OFF_CH_HIGH: begin
                    if (high_ok) begin
                        high_reg[ch_sel_reg] <= wdata_s;
                    end
                end
                OFF_CH_LOW: begin
                    if (low_ok) begin
                        low_reg[ch_sel_reg] <= wdata_s;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ch_sel_reg    <= '0;
            mem_index_reg <= '0;
        end else if (wr && paddr == OFF_CH_SEL) begin
            ch_sel_reg <= pwdata[CH_W-1:0];
        end else if (wr && paddr == OFF_MEM_INDEX) begin
            mem_index_reg <= pwdata[MEM_IDX_W-1:0];
        end
    end

    // ==========================================================
    // Reading memory
    // ==========================================================
    // Erasing only resets the fill count; entries at or beyond it read back as zero.
    logic [MEM_CNT_W-1:0] mem_base;
    logic                 mem_room;

    assign mem_base = (scan_start || preset) ? '0 : mem_count_reg;
    assign mem_room = mem_base != MEM_DEPTH_V;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_count_reg <= '0;
        end else if (reading_valid && mem_room) begin
            mem_count_reg <= mem_base + 1'b1;
        end else begin
            mem_count_reg <= mem_base;
        end
    end

    always_ff @(posedge pclk) begin
        if (reading_valid && mem_room) begin
            mem_reg[mem_base[MEM_IDX_W-1:0]] <= '{channel: reading.channel, value: reading.value,
                                                  in_alarm: r_alarm, high_hit: r_hi_hit,
                                                  low_hit: r_lo_hit, alarm_num: r_num};
        end
    end

    // ==========================================================
    // Alarm queue
    // ==========================================================
    logic q_push;
    logic q_pop;
    logic q_drop;

    assign q_pop  = rd && paddr == OFF_Q_READING && q_count_reg != '0;
    assign q_push = r_alarm && q_count_reg != QDEPTH_V;
    assign q_drop = r_alarm && q_count_reg == QDEPTH_V;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q_head_reg  <= '0;
            q_tail_reg  <= '0;
            q_count_reg <= '0;
        end else if (preset) begin
            q_head_reg  <= '0;
            q_tail_reg  <= '0;
            q_count_reg <= '0;
        end else begin
            if (q_push) begin
                q_tail_reg <= qinc(q_tail_reg);
            end
            if (q_pop) begin
                q_head_reg <= qinc(q_head_reg);
            end
            if (q_push && !q_pop) begin
                q_count_reg <= q_count_reg + 1'b1;
            end else if (q_pop && !q_push) begin
                q_count_reg <= q_count_reg - 1'b1;
            end
        end
    end

    always_ff @(posedge pclk) begin
        if (q_push) begin
            q_reg[q_tail_reg] <= '{channel: reading.channel, value: reading.value,
                                   stamp: reading.stamp, alarm_num: r_num};
        end
    end

    // ==========================================================
    // Interrupts
    // ==========================================================
    logic [EV_W-1:0] events;

    always_comb begin
        events = '0;
        events[r_num] = r_alarm;
        events[EV_DROP_BIT] = q_drop;
    end

    // A clear in the same cycle as a new event loses to the event.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_status_reg <= '0;
            int_enable_reg <= '0;
            irq_reg        <= 1'b0;
        end else begin
            if (wr && paddr == OFF_INT_CLEAR) begin
                int_status_reg <= (int_status_reg & ~pwdata[EV_W-1:0]) | events;
            end else begin
                int_status_reg <= int_status_reg | events;
            end
            if (wr && paddr == OFF_INT_ENABLE) begin
                int_enable_reg <= pwdata[EV_W-1:0];
            end
            irq_reg <= |(int_status_reg & int_enable_reg);
        end
    end

    // ==========================================================
    // Read data and response
    // ==========================================================
    logic [31:0]          rdata;
    salm_queue_entry_type q_head;
    salm_mem_entry_type   m_ent;
    logic                 q_any;
    logic                 m_any;
    logic                 refused;

    assign q_head  = q_reg[q_head_reg];
    assign m_ent   = mem_reg[mem_index_reg];
    assign q_any   = q_count_reg != '0;
    assign m_any   = {1'b0, mem_index_reg} < mem_count_reg;
    assign refused = !mapped
                     || (pwrite && paddr == OFF_CH_HIGH && !high_ok)
                     || (pwrite && paddr == OFF_CH_LOW && !low_ok);

    always_comb begin
        rdata = '0;
        case (paddr)
            OFF_CH_SEL:     rdata[CH_W-1:0] = ch_sel_reg;
            OFF_CH_CFG: begin
                rdata[CFG_ALARM_LSB +: 2] = anum_reg[ch_sel_reg];
                rdata[CFG_MODE_LSB +: 2]  = mode_reg[ch_sel_reg];
            end
            OFF_CH_HIGH:    rdata = sel_high;
            OFF_CH_LOW:     rdata = sel_low;
            OFF_MEAS_CFG:   rdata = meas_reg[ch_sel_reg];
            OFF_INT_STATUS: rdata[EV_W-1:0] = int_status_reg;
            OFF_INT_ENABLE: rdata[EV_W-1:0] = int_enable_reg;
            OFF_Q_COUNT:    rdata[QPTR_W-1:0] = q_count_reg;
            OFF_Q_INFO:     rdata = q_any ? status_word(q_head.channel, q_head.alarm_num, 1'b1, 1'b0, 1'b0) : '0;
            OFF_Q_TIME:     rdata = q_any ? q_head.stamp : '0;
            OFF_Q_READING:  rdata = q_any ? q_head.value : '0;
            OFF_MEM_COUNT:  rdata[MEM_CNT_W-1:0] = mem_count_reg;
            OFF_MEM_INDEX:  rdata[MEM_IDX_W-1:0] = mem_index_reg;
            OFF_MEM_DATA:   rdata = m_any ? m_ent.value : '0;
            OFF_MEM_STATUS: rdata = m_any ? status_word(m_ent.channel, m_ent.alarm_num, m_ent.in_alarm,
                                                        m_ent.high_hit, m_ent.low_hit) : '0;
            default:        rdata = '0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg  <= '0;
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
        end else begin
            pready_reg  <= setup;
            pslverr_reg <= setup && refused;
            if (rd) begin
                prdata_reg <= rdata;
            end
        end
    end

endmodule
`default_nettype wire

/* logic/salm_pkg.sv */
`default_nettype none
package salm_pkg;

    // ==========================================================
    // Sizes
    // ==========================================================
    localparam int NUM_CH    = 8;
    localparam int CH_W      = 3;
    localparam int DATA_W    = 32;
    localparam int TIME_W    = 32;
    localparam int NUM_ALARM = 4;
    localparam int QDEPTH    = 20;
    localparam int QPTR_W    = 5;
    localparam int MEM_DEPTH = 16;
    localparam int MEM_IDX_W = 4;
    localparam int MEM_CNT_W = 5;
    localparam int EV_W      = 5;

    localparam logic [QPTR_W-1:0]    QDEPTH_V    = 5'h14;
    localparam logic [QPTR_W-1:0]    QLAST_V     = 5'h13;
    localparam logic [MEM_CNT_W-1:0] MEM_DEPTH_V = 5'h10;

    // ==========================================================
    // Register byte offsets
    // ==========================================================
    localparam logic [7:0] OFF_CTRL       = 8'h00;
    localparam logic [7:0] OFF_CH_SEL     = 8'h04;
    localparam logic [7:0] OFF_CH_CFG     = 8'h08;
    localparam logic [7:0] OFF_CH_HIGH    = 8'h0c;
    localparam logic [7:0] OFF_CH_LOW     = 8'h10;
    localparam logic [7:0] OFF_MEAS_CFG   = 8'h14;
    localparam logic [7:0] OFF_INT_STATUS = 8'h18;
    localparam logic [7:0] OFF_INT_CLEAR  = 8'h1c;
    localparam logic [7:0] OFF_INT_ENABLE = 8'h20;
    localparam logic [7:0] OFF_Q_COUNT    = 8'h24;
    localparam logic [7:0] OFF_Q_INFO     = 8'h28;
    localparam logic [7:0] OFF_Q_TIME     = 8'h2c;
    localparam logic [7:0] OFF_Q_READING  = 8'h30;
    localparam logic [7:0] OFF_MEM_COUNT  = 8'h34;
    localparam logic [7:0] OFF_MEM_INDEX  = 8'h38;
    localparam logic [7:0] OFF_MEM_DATA   = 8'h3c;
    localparam logic [7:0] OFF_MEM_STATUS = 8'h40;

    // ==========================================================
    // Field positions
    // ==========================================================
    localparam int CTRL_FACTORY_BIT = 0;
    localparam int CTRL_PRESET_BIT  = 1;
    localparam int CFG_ALARM_LSB    = 0;
    localparam int CFG_MODE_LSB     = 2;
    localparam int ST_ALARM_BIT     = 0;
    localparam int ST_HIGH_BIT      = 1;
    localparam int ST_LOW_BIT       = 2;
    localparam int ST_NUM_LSB       = 3;
    localparam int ST_CH_LSB        = 8;
    localparam int EV_DROP_BIT      = 4;

    typedef enum logic [1:0] {
        alarm_off_mode,
        high_limit_only_mode,
        low_limit_only_mode,
        both_limits_mode
    } salm_mode_type;

    typedef struct packed {
        logic [CH_W-1:0]          channel;
        logic signed [DATA_W-1:0] value;
        logic [TIME_W-1:0]        stamp;
    } salm_reading_type;

    typedef struct packed {
        logic [CH_W-1:0]          channel;
        logic signed [DATA_W-1:0] value;
        logic                     in_alarm;
        logic                     high_hit;
        logic                     low_hit;
        logic [1:0]               alarm_num;
    } salm_mem_entry_type;

    typedef struct packed {
        logic [CH_W-1:0]          channel;
        logic signed [DATA_W-1:0] value;
        logic [TIME_W-1:0]        stamp;
        logic [1:0]               alarm_num;
    } salm_queue_entry_type;

endpackage
`default_nettype wire

/* tb/salm_monitor_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module salm_monitor_asserts
    import salm_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        reading_valid,
    input wire logic        irq
);
    // ==========================================================
    // Bus phases
    // ==========================================================
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence setup_s;
        psel && !penable;
    endsequence
    sequence rd_setup_s;
        psel && !penable && !pwrite;
    endsequence
    // ==========================================================
    // Properties
    // ==========================================================
    chk_ready_after_setup: assert property (setup_s |=> pready) else $error("pready missing after setup");
    chk_ready_has_setup: assert property (pready |-> $past(psel && !penable)) else $error("pready without setup");
    chk_ready_one_cycle: assert property (pready |=> !pready) else $error("pready longer than one cycle");
    chk_err_with_ready: assert property (pslverr |-> pready) else $error("pslverr without pready");
    chk_unmapped_read: assert property (rd_setup_s ##0 (paddr > 8'h40) |=> pslverr && prdata == 32'h0)
        else $error("unmapped read not refused");
    chk_unmapped_write: assert property (setup_s ##0 (paddr > 8'h40) |=> pslverr) else $error("unmapped write ok");
    // Read data is only refreshed by a read; a write or idle cycle must leave it alone.
    chk_rdata_holds: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
        else $error("prdata changed without read");
    chk_irq_rise_cause: assert property ($rose(irq) |-> $past(reading_valid, 2) || $past(psel && !penable && pwrite, 2))
        else $error("irq rose without cause");
    chk_irq_fall_cause: assert property ($fell(irq) |-> $past(psel && !penable && pwrite, 2))
        else $error("irq fell without write");
endmodule
bind salm_monitor salm_monitor_asserts u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .reading_valid(reading_valid), .irq(irq));
`default_nettype wire

/* tb/salm_monitor_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module salm_monitor_tb_top import salm_pkg::*; ;
    logic             pclk, presetn, psel, penable, pwrite, irq, pready, pslverr, scan_start, reading_valid, er;
    logic [7:0]       paddr;
    logic [31:0]      pwdata, prdata, rd, seed;
    salm_reading_type reading;
    int               num_errors = 0, n_tests = 0, cyc = 0, hi[8], lo[8], mv[$], qv[$];
    logic [1:0]       md[8], an[8];
    logic [10:0]      ms[$], qi[$];
    logic [31:0]      qs[$];
    logic [4:0]       st, en;
    int               tbl[5] = '{101, 100, -100, -101, 0};
    salm_monitor dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .scan_start(scan_start), .reading_valid(reading_valid), .reading(reading), .irq(irq));
    salm_seq_model u_seq (.pclk(pclk), .scan_start(scan_start), .reading_valid(reading_valid), .reading(reading));
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 8000) begin
            num_errors++;
            results();
        end
    end
    // ==========================================================
    // Tasks
    // ==========================================================
    task automatic results();
        $display("errors %0d tests %0d", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            $display("ERROR %s expected %h seen %h", nm, e, g);
            num_errors++;
        end
    endtask
    task automatic chk1(input string nm, input logic e, input logic g);
        n_tests++;
        if (g !== e) begin
            $display("ERROR %s expected %b seen %b", nm, e, g);
            num_errors++;
        end
    endtask
    // The wait has no limit of its own: a slave that never answers runs into the cycle ceiling.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = 32'hffffffff);
        apb(1'b0, a, 32'h0);
        chk($sformatf("reg_%h", a), e & m, rd & m);
    endtask
    task automatic cfg(input int c, input logic [1:0] m, input logic [1:0] a);
        wr(OFF_CH_SEL, c);
        wr(OFF_MEAS_CFG, $urandom);
        wr(OFF_CH_HIGH, 100);
        wr(OFF_CH_LOW, -100);
        wr(OFF_CH_CFG, {m, a});
        hi[c] = 100; lo[c] = -100; md[c] = m; an[c] = a;
    endtask
    // Reference check of one reading: strict limits, sticky status, memory and a queue that never overwrites.
    task automatic feed(input int c, input int v, input logic ns);
        logic h, l;
        logic [31:0] s;
        s = $urandom;
        h = md[c][0] && v > hi[c];
        l = md[c][1] && v < lo[c];
        if (ns) begin mv.delete(); ms.delete(); end
        if (mv.size() < 16) begin mv.push_back(v); ms.push_back({3'(c), 3'b0, an[c], l, h, h | l}); end
        if (h | l) begin
            st[an[c]] = 1'b1;
            if (qv.size() < 20) begin qv.push_back(v); qs.push_back(s); qi.push_back({3'(c), 3'b0, an[c], 3'b001}); end
            else st[4] = 1'b1;
        end
        u_seq.send(3'(c), v, s, ns);
    endtask
    task automatic mem_check();
        rdc(OFF_MEM_COUNT, mv.size());
        foreach (mv[i]) begin
            wr(OFF_MEM_INDEX, i);
            rdc(OFF_MEM_DATA, mv[i]);
            rdc(OFF_MEM_STATUS, ms[i], ms[i][0] ? 32'hffffffff : 32'h707);
        end
    endtask
    task automatic drain();
        rdc(OFF_Q_COUNT, qv.size());
        while (qv.size() > 0) begin
            rdc(OFF_Q_INFO, qi.pop_front());
            rdc(OFF_Q_TIME, qs.pop_front());
            rdc(OFF_Q_READING, qv.pop_front());
        end
        rdc(OFF_Q_COUNT, 0);
    endtask
    // ==========================================================
    // Main sequence
    // ==========================================================
    initial begin
        presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0;
        st = 5'h00; en = 5'h00;
        seed = $urandom(86);
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        wr(OFF_CH_SEL, 3);
        rdc(OFF_CH_HIGH, 0);
        rdc(OFF_CH_LOW, 0);
        for (int c = 0; c < 8; c++) cfg(c, 2'(c % 4), 2'(c / 2));
        wr(OFF_CH_SEL, 2);
        apb(1'b1, OFF_CH_LOW, 200);
        chk1("low_refused", 1'b1, er);
        apb(1'b1, OFF_CH_HIGH, -200);
        chk1("high_refused", 1'b1, er);
        rdc(OFF_CH_HIGH, 100);
        rdc(OFF_CH_LOW, -100);
        rdc(OFF_CH_CFG, 32'h9);
        wr(OFF_INT_ENABLE, 32'h1f);
        en = 5'h1f;
        for (int i = 0; i < 17; i++) feed(i % 8, (i % 5 == 4) ? int'($urandom) : tbl[i % 5], i == 0);
        mem_check();
        rdc(OFF_INT_STATUS, st);
        chk1("irq", |(st & en), irq);
        drain();
        wr(OFF_INT_CLEAR, 32'h1f);
        st = 5'h00;
        rdc(OFF_INT_STATUS, 0);
        chk1("irq", 1'b0, irq);
        for (int i = 0; i < 22; i++) feed(1, 101 + i, i == 0);
        mem_check();
        rdc(OFF_INT_STATUS, st);
        drain();
        wr(OFF_INT_ENABLE, 0);
        en = 5'h00;
        wr(OFF_INT_CLEAR, 32'h1f);
        st = 5'h00;
        feed(3, 200, 1'b0);
        rdc(OFF_INT_STATUS, st);
        chk1("irq_masked", 1'b0, irq);
        wr(OFF_INT_ENABLE, 32'h1f);
        en = 5'h1f;
        rdc(OFF_INT_ENABLE, 32'h1f);
        chk1("irq", 1'b1, irq);
        wr(OFF_CTRL, 32'h2);
        mv.delete(); ms.delete(); qv.delete(); qs.delete(); qi.delete();
        wr(OFF_CH_SEL, 3);
        rdc(OFF_CH_HIGH, 100);
        rdc(OFF_CH_CFG, 32'hd);
        rdc(OFF_MEM_COUNT, 0);
        rdc(OFF_Q_COUNT, 0);
        wr(OFF_CTRL, 32'h1);
        for (int c = 0; c < 8; c++) begin hi[c] = 0; lo[c] = 0; md[c] = 2'b00; end
        rdc(OFF_CH_HIGH, 0);
        rdc(OFF_CH_LOW, 0);
        rdc(OFF_CH_CFG, 0, 32'hc);
        feed(3, 500, 1'b0);
        rdc(OFF_Q_COUNT, qv.size());
        cfg(5, 2'b11, 2'b10);
        wr(OFF_MEAS_CFG, 7);
        rdc(OFF_MEAS_CFG, 7);
        hi[5] = 0; lo[5] = 0; md[5] = 2'b00;
        rdc(OFF_CH_HIGH, 0);
        rdc(OFF_CH_LOW, 0);
        rdc(OFF_CH_CFG, 0, 32'hc);
        feed(5, 300, 1'b0);
        rdc(OFF_Q_COUNT, qv.size());
        apb(1'b0, 8'h80, 32'h0);
        chk1("unmapped_err", 1'b1, er);
        chk("unmapped_data", 32'h0, rd);
        apb(1'b1, 8'h80, 32'h5);
        chk1("unmapped_werr", 1'b1, er);
        results();
    end
endmodule
`default_nettype wire

/* tb/salm_seq_model.sv */
`timescale 1ns/1ps
`default_nettype none
module salm_seq_model
    import salm_pkg::*;
(
    input wire logic         pclk,
    output logic             scan_start,
    output logic             reading_valid,
    output salm_reading_type reading
);
    initial begin
        scan_start = 1'b0;
        reading_valid = 1'b0;
        reading = '0;
    end
    // After each valid cycle the bus carries inverted junk so stale data is never mistaken for a reading.
    task automatic send(input logic [2:0] c, input int v, input logic [31:0] s, input logic ns);
        @(posedge pclk);
        scan_start <= ns;
        reading_valid <= 1'b1;
        reading <= '{channel: c, value: v, stamp: s};
        @(posedge pclk);
        scan_start <= 1'b0;
        reading_valid <= 1'b0;
        reading <= salm_reading_type'(~{c, v, s});
    endtask
endmodule
`default_nettype wire
